// ---- fcd_defs.svh ----
/*
  Constants of the fuse configuration decoder: byte offsets, field
  positions, encodings and timing figures.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

// Register offsets, byte addresses on the 8-bit register port
`define FCD_OFS_OSC_CFG 8'h02
`define FCD_OFS_SYS_OPT_A 8'h05
`define FCD_OFS_STARTUP 8'h06
`define FCD_OFS_APP_END 8'h07
`define FCD_OFS_BOOT_END 8'h08
`define FCD_OFS_LOCK_KEY 8'h0a
`define FCD_OFS_CAL_A 8'h10
`define FCD_OFS_CAL_B 8'h11
`define FCD_OFS_STATUS 8'h12

// Field positions
`define FCD_OSC_LOCK_BIT 7
`define FCD_FREQ_SEL_MSB 1
`define FCD_FREQ_SEL_LSB 0
`define FCD_CRC_SRC_MSB 7
`define FCD_CRC_SRC_LSB 6
`define FCD_PIN_FN_MSB 3
`define FCD_PIN_FN_LSB 2
`define FCD_EE_KEEP_BIT 0
`define FCD_SUT_MSB 2
`define FCD_SUT_LSB 0
`define FCD_CAL_B_LOCK_BIT 7
`define FCD_TEMP_TRIM_MSB 3

// Encodings
`define FCD_FREQ_16M 2'h1
`define FCD_FREQ_20M 2'h2
`define FCD_UNLOCK_KEY 8'hc5

// Reset value of every holding register; fuse defaults are not reset values
`define FCD_RST_BYTE 8'h00

// Flash size in 256-byte blocks
`define FCD_FLASH_BLOCKS 9'h010

// Timing
`define FCD_CLK_PERIOD_NS 10
`define FCD_MS_NS 1000000
`define FCD_PIN_HOLD_SLOW_CYCLES 10'h300

`endif

// ---- fcd_pkg.sv ----
/*
  Types of the fuse configuration decoder.
  Assumes fcd_defs.svh for the constants that sit beside these types.
*/
package fcd_pkg;

  typedef enum logic [1:0] {
    FCD_CRC_FULL,
    FCD_CRC_BOOT,
    FCD_CRC_BOOT_APP,
    FCD_CRC_NONE
  } fcd_crc_src_e;

  typedef enum logic [1:0] {
    FCD_PIN_GPIO,
    FCD_PIN_PROG,
    FCD_PIN_RESET,
    FCD_PIN_RSVD
  } fcd_pin_fn_e;

  // Raw configuration bytes as delivered by the non-volatile array
  typedef struct packed {
    logic [7:0] osc_cfg;
    logic [7:0] sys_opt_a;
    logic [7:0] startup;
    logic [7:0] app_end;
    logic [7:0] boot_end;
    logic [7:0] lock_key;
  } fcd_fuse_s;

  // Factory trim values for one oscillator frequency
  typedef struct packed {
    logic [7:0] freq_trim;
    logic [3:0] temp_trim;
  } fcd_trim_s;

  typedef struct packed {
    logic [8:0] boot_end_block;
    logic [8:0] app_end_block;
  } fcd_sections_s;

endpackage

// ---- fcd_sync2.sv ----
/*
  Two-flop synchroniser for one level from outside the sys_clk domain.
  Assumes the source toggles far slower than sys_clk.
*/
`timescale 1ns/100ps
module fcd_sync2
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- fcd_top.sv ----
/*
  Fuse configuration decoder: samples the configuration bytes once after
  reset and turns them into oscillator, CRC scan, shared pin, erase,
  start-up, section and lock controls; software reads them on a port.
  Assumes static fuse and trim inputs from sys_clk logic, a slow oscillator
  arriving asynchronously, and a CRC unit answering on sys_clk.
*/
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "fcd_defs.svh"
module fcd_top
#(
  parameter int STARTUP_UNIT_CYCLES = `FCD_MS_NS / `FCD_CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Configuration and factory trim sources
  input wire fcd_pkg::fcd_fuse_s fuse_bytes,
  input wire fcd_pkg::fcd_trim_s trim_16m,
  input wire fcd_pkg::fcd_trim_s trim_20m,
  // Slow internal oscillator, asynchronous
  input wire logic slow_internal_osc,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Main oscillator control
  output logic osc_run_16m,
  output logic osc_run_20m,
  output logic [7:0] osc_freq_trim,
  output logic [3:0] osc_temp_trim,
  // Memory CRC unit
  output logic crc_start,
  output fcd_pkg::fcd_crc_src_e crc_scan_source,
  output logic [8:0] crc_end_block,
  input wire logic crc_done,
  // Start-up
  output logic cpu_run,
  // Flash sections
  output fcd_pkg::fcd_sections_s sections,
  // Shared pin
  output fcd_pkg::fcd_pin_fn_e shared_pin_function,
  input wire logic gpio_out_req,
  input wire logic gpio_oe_req,
  output logic shared_pin_o,
  output logic shared_pin_oe,
  output logic pin_irq_allowed,
  // Chip erase
  input wire logic chip_erase_req,
  output logic flash_erase,
  output logic eeprom_erase,
  // Programming interface access
  input wire logic prog_bus_req,
  input wire logic prog_info_req,
  output logic prog_bus_grant,
  output logic prog_info_grant
);
  import fcd_pkg::*;

  typedef enum logic [1:0] {
    FCD_ST_LOAD,
    FCD_ST_CRC,
    FCD_ST_WAIT,
    FCD_ST_RUN
  } fcd_state_e;

  localparam logic [23:0] UNIT_CYCLES = 24'(STARTUP_UNIT_CYCLES);

  // Holding registers
  fcd_fuse_s held;
  logic loaded;
  logic [7:0] cal_a;
  logic [7:0] cal_b;
  fcd_state_e state;
  fcd_state_e next_state;
  logic [23:0] wait_cnt;
  logic [9:0] slow_cnt;
  logic slow_sync;
  logic slow_prev;
  logic pin_hold_done;

  // Decoded fields
  wire [1:0] freq_sel = held.osc_cfg[`FCD_FREQ_SEL_MSB:`FCD_FREQ_SEL_LSB];
  wire fuse_osc_lock = held.osc_cfg[`FCD_OSC_LOCK_BIT];
  wire [1:0] crc_src_raw = held.sys_opt_a[`FCD_CRC_SRC_MSB:`FCD_CRC_SRC_LSB];
  wire [1:0] pin_fn_raw = held.sys_opt_a[`FCD_PIN_FN_MSB:`FCD_PIN_FN_LSB];
  wire ee_keep = held.sys_opt_a[`FCD_EE_KEEP_BIT];
  wire [2:0] startup_delay_sel = held.startup[`FCD_SUT_MSB:`FCD_SUT_LSB];
  wire cal_locked = cal_b[`FCD_CAL_B_LOCK_BIT];
  wire unlocked = (held.lock_key == `FCD_UNLOCK_KEY);
  wire is_20m = (freq_sel == `FCD_FREQ_20M);
  wire is_16m = (freq_sel == `FCD_FREQ_16M);
  // Reserved frequency codes keep the 20 MHz trim, though neither oscillator runs
  wire fcd_trim_s trim_sel = is_16m ? trim_16m : trim_20m;

  // Section boundaries
  wire boot_zero = (held.boot_end == 8'h00);
  wire app_zero = (held.app_end == 8'h00);
  wire [8:0] boot_end_w = boot_zero ? `FCD_FLASH_BLOCKS : {1'b0, held.boot_end};
  // Either zero: app end is flash top, as a zero boot end covers flash as well
  wire [8:0] app_end_w = (app_zero || boot_zero) ? `FCD_FLASH_BLOCKS
                                               : {1'b0, held.app_end};
  wire [8:0] crc_end_w = (crc_src_raw == 2'h1) ? boot_end_w
                       : (crc_src_raw == 2'h2) ? app_end_w
                       : `FCD_FLASH_BLOCKS;
  wire crc_skip = (crc_src_raw == 2'h3);

  // Start-up delay: unit shifted by code minus one, code zero means none
  wire [2:0] sut_shift = startup_delay_sel - 3'h1;
  wire [23:0] startup_cycles = (startup_delay_sel == 3'h0) ? 24'h000000 : (UNIT_CYCLES << sut_shift);

  // Register port decode
  wire wr_cal_a = reg_wr && (reg_addr == `FCD_OFS_CAL_A) && !cal_locked;
  wire wr_cal_b = reg_wr && (reg_addr == `FCD_OFS_CAL_B) && !cal_locked;
  wire wr_lock = reg_wr && (reg_addr == `FCD_OFS_LOCK_KEY);
  logic crc_done_seen;
  wire [7:0] status_w = {3'h0, unlocked, pin_hold_done, crc_done_seen, cpu_run, loaded};
  logic [7:0] rd_mux;

  always_comb
  begin
    unique case (reg_addr)
      `FCD_OFS_OSC_CFG: rd_mux = held.osc_cfg;
      `FCD_OFS_SYS_OPT_A: rd_mux = held.sys_opt_a;
      `FCD_OFS_STARTUP: rd_mux = held.startup;
      `FCD_OFS_APP_END: rd_mux = held.app_end;
      `FCD_OFS_BOOT_END: rd_mux = held.boot_end;
      `FCD_OFS_LOCK_KEY: rd_mux = held.lock_key;
      `FCD_OFS_CAL_A: rd_mux = cal_a;
      `FCD_OFS_CAL_B: rd_mux = cal_b;
      `FCD_OFS_STATUS: rd_mux = status_w;
      default: rd_mux = 8'h00;
    endcase
  end

  // Sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      FCD_ST_LOAD: next_state = crc_skip ? FCD_ST_WAIT : FCD_ST_CRC;
      FCD_ST_CRC: next_state = crc_done ? FCD_ST_WAIT : FCD_ST_CRC;
      FCD_ST_WAIT: next_state = (wait_cnt >= startup_cycles) ? FCD_ST_RUN : FCD_ST_WAIT;
      FCD_ST_RUN: next_state = FCD_ST_RUN;
    endcase
  end

  // Fuse capture: one clocked sample after reset release, then frozen but for lock_key writes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      held <= '{default: `FCD_RST_BYTE};
      loaded <= 1'b0;
    end
    else if (!loaded)
    begin
      held <= fuse_bytes;
      loaded <= 1'b1;
    end
    else if (wr_lock)
    begin
      held.lock_key <= reg_wdata;
    end
  end

  // Calibration registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_a <= `FCD_RST_BYTE;
      cal_b <= `FCD_RST_BYTE;
    end
    else if (state == FCD_ST_LOAD && loaded)
    begin
      cal_a <= trim_sel.freq_trim;
      cal_b <= {fuse_osc_lock, 3'h0, trim_sel.temp_trim};
    end
    else
    begin
      if (wr_cal_a)
        cal_a <= reg_wdata;
      // Lock bit stays as loaded; software cannot lift it
      if (wr_cal_b)
        cal_b <= {cal_b[`FCD_CAL_B_LOCK_BIT], 3'h0, reg_wdata[`FCD_TEMP_TRIM_MSB:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= FCD_ST_LOAD;
    else if (loaded)
      state <= next_state;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wait_cnt <= 24'h000000;
    else if (state == FCD_ST_WAIT)
      wait_cnt <= wait_cnt + 24'h000001;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      crc_done_seen <= 1'b0;
    else if (state == FCD_ST_CRC && crc_done)
      crc_done_seen <= 1'b1;
  end

  // Slow oscillator edge count for the pin driver hold-off
  fcd_sync2 u_slow_sync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(slow_internal_osc),
    .sync_out(slow_sync)
  );

  assign pin_hold_done = (slow_cnt == `FCD_PIN_HOLD_SLOW_CYCLES);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slow_prev <= 1'b0;
      slow_cnt <= 10'h000;
    end
    else
    begin
      slow_prev <= slow_sync;
      if (slow_sync && !slow_prev && !pin_hold_done)
        slow_cnt <= slow_cnt + 10'h001;
    end
  end

  // Output registers
  wire pin_gpio = (pin_fn_raw == 2'h0);
  wire erase_ee_w = chip_erase_req && (!ee_keep || !unlocked);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // Oscillator trims trail the calibration registers by one cycle; run bits follow the held frequency code
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_run_16m <= 1'b0;
      osc_run_20m <= 1'b0;
      osc_freq_trim <= 8'h00;
      osc_temp_trim <= 4'h0;
    end
    else
    begin
      osc_run_16m <= loaded && is_16m;
      osc_run_20m <= loaded && is_20m;
      osc_freq_trim <= cal_a;
      osc_temp_trim <= cal_b[`FCD_TEMP_TRIM_MSB:0];
    end
  end

  // Scan request, start-up and section limits
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_start <= 1'b0;
      crc_scan_source <= FCD_CRC_NONE;
      crc_end_block <= 9'h000;
      cpu_run <= 1'b0;
      sections <= '0;
    end
    else
    begin
      crc_start <= (state == FCD_ST_LOAD) && loaded && !crc_skip;
      crc_scan_source <= fcd_crc_src_e'(crc_src_raw);
      crc_end_block <= crc_end_w;
      cpu_run <= (state == FCD_ST_RUN);
      sections <= '{boot_end_block: boot_end_w, app_end_block: app_end_w};
    end
  end

  // Shared pin: reserved function until the fuses are in
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shared_pin_function <= FCD_PIN_RSVD;
      shared_pin_o <= 1'b0;
      shared_pin_oe <= 1'b0;
      pin_irq_allowed <= 1'b0;
    end
    else
    begin
      shared_pin_function <= loaded ? fcd_pin_fn_e'(pin_fn_raw) : FCD_PIN_RSVD;
      shared_pin_o <= gpio_out_req;
      shared_pin_oe <= loaded && pin_gpio && pin_hold_done && gpio_oe_req;
      pin_irq_allowed <= pin_hold_done;
    end
  end

  // Erase and programming interface access
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flash_erase <= 1'b0;
      eeprom_erase <= 1'b0;
      prog_bus_grant <= 1'b0;
      prog_info_grant <= 1'b0;
    end
    else
    begin
      flash_erase <= chip_erase_req;
      eeprom_erase <= erase_ee_w;
      prog_bus_grant <= loaded && unlocked && prog_bus_req;
      prog_info_grant <= prog_info_req;
    end
  end
endmodule

// ---- fcd_top_sva.sv ----
/*
  Port checker for the fuse configuration decoder.
  Assumes it is bound to fcd_top and sees one sys_clk domain.
*/
`timescale 1ns/100ps
module fcd_top_sva
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Observed ports
  input wire logic osc_run_16m,
  input wire logic osc_run_20m,
  input wire logic crc_start,
  input wire fcd_pkg::fcd_crc_src_e crc_scan_source,
  input wire logic cpu_run,
  input wire fcd_pkg::fcd_pin_fn_e shared_pin_function,
  input wire logic gpio_oe_req,
  input wire logic shared_pin_oe,
  input wire logic chip_erase_req,
  input wire logic flash_erase,
  input wire logic eeprom_erase,
  input wire logic prog_bus_req,
  input wire logic prog_info_req,
  input wire logic prog_bus_grant,
  input wire logic prog_info_grant
);
  import fcd_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  osc_excl_a: assert property (!(osc_run_16m && osc_run_20m))
    else $error("both oscillator speeds selected");
  crc_pulse_a: assert property (crc_start |=> !crc_start)
    else $error("scan start longer than one cycle");
  crc_none_a: assert property (crc_start |-> crc_scan_source != FCD_CRC_NONE)
    else $error("scan started with no check selected");
  cpu_hold_a: assert property ($rose(cpu_run) |=> cpu_run [*4])
    else $error("cpu run dropped");
  pin_gpio_a: assert property (shared_pin_oe |->
    shared_pin_function == FCD_PIN_GPIO && $past(gpio_oe_req))
    else $error("pin driven outside gpio mode");
  erase_flash_a: assert property (chip_erase_req |=> flash_erase)
    else $error("flash erase missing");
  erase_cause_a: assert property (eeprom_erase |-> $past(chip_erase_req))
    else $error("eeprom erase without request");
  bus_cause_a: assert property (prog_bus_grant |-> $past(prog_bus_req))
    else $error("bus grant without request");
  info_grant_a: assert property (prog_info_req |=> prog_info_grant)
    else $error("info block grant missing");
endmodule

bind fcd_top fcd_top_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b),
  .osc_run_16m(osc_run_16m), .osc_run_20m(osc_run_20m), .crc_start(crc_start),
  .crc_scan_source(crc_scan_source), .cpu_run(cpu_run),
  .shared_pin_function(shared_pin_function), .gpio_oe_req(gpio_oe_req),
  .shared_pin_oe(shared_pin_oe), .chip_erase_req(chip_erase_req),
  .flash_erase(flash_erase), .eeprom_erase(eeprom_erase), .prog_bus_req(prog_bus_req),
  .prog_info_req(prog_info_req), .prog_bus_grant(prog_bus_grant),
  .prog_info_grant(prog_info_grant));

// ---- fcd_top_bench.sv ----
/*
  Self-checking bench for the fuse configuration decoder.
  Assumes fcd_top with a start-up unit of 4 cycles and a free slow oscillator.
*/
`timescale 1ns/100ps
`include "fcd_defs.svh"
module fcd_top_bench;
  import fcd_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, slow_osc = 1'b0, crc_done = 1'b0, gpio_oe_req = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, chip_erase_req = 1'b0, prog_bus_req = 1'b0;
  logic prog_info_req = 1'b0, gpio_out_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_val, reg_rdata, osc_freq_trim;
  fcd_fuse_s fuse_bytes = '0;
  fcd_trim_s trim_16m = {8'h3a, 4'h5}, trim_20m = {8'h6c, 4'h9};
  logic [3:0] osc_temp_trim;
  logic osc_run_16m, osc_run_20m, crc_start, cpu_run, shared_pin_oe, pin_irq_allowed;
  logic flash_erase, eeprom_erase, prog_bus_grant, prog_info_grant, shared_pin_o;
  logic [8:0] crc_end_block;
  fcd_crc_src_e crc_scan_source;
  fcd_sections_s sections;
  fcd_pin_fn_e shared_pin_function;
  int num_errors = 0, tests_run = 0;
  time t0;

  always #5 sys_clk = ~sys_clk;
  // Slow oscillator runs free, unrelated to the reset release
  always #40 slow_osc = ~slow_osc;

  fcd_top #(.STARTUP_UNIT_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .fuse_bytes(fuse_bytes), .trim_16m(trim_16m), .trim_20m(trim_20m),
    .slow_internal_osc(slow_osc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_run_16m(osc_run_16m),
    .osc_run_20m(osc_run_20m), .osc_freq_trim(osc_freq_trim), .osc_temp_trim(osc_temp_trim),
    .crc_start(crc_start), .crc_scan_source(crc_scan_source), .crc_end_block(crc_end_block),
    .crc_done(crc_done), .cpu_run(cpu_run), .sections(sections),
    .shared_pin_function(shared_pin_function), .gpio_out_req(gpio_out_req),
    .gpio_oe_req(gpio_oe_req), .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
    .pin_irq_allowed(pin_irq_allowed), .chip_erase_req(chip_erase_req),
    .flash_erase(flash_erase), .eeprom_erase(eeprom_erase), .prog_bus_req(prog_bus_req),
    .prog_info_req(prog_info_req), .prog_bus_grant(prog_bus_grant),
    .prog_info_grant(prog_info_grant));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task start(input fcd_fuse_s f);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    fuse_bytes <= f;
    repeat (2) @(posedge sys_clk);
    chk({reg_rdata, cpu_run, osc_freq_trim}, 0);
    rst_b <= 1'b1;
    t0 = $time;
  endtask

  // Waits for the scan (answered at once) and times the start-up delay
  task seq(input logic use_crc, input int n);
    int c;
    logic s;
    c = 0;
    s = 1'b0;
    if (use_crc)
    begin
      while (crc_start !== 1'b1 && c < 20)
      begin
        @(posedge sys_clk);
        #1 c++;
      end
      chk(crc_start, 1);
      @(posedge sys_clk);
      crc_done <= 1'b1;
      @(posedge sys_clk);
      crc_done <= 1'b0;
      c = 0;
    end
    while (cpu_run !== 1'b1 && c < 400)
    begin
      @(posedge sys_clk);
      #1 c++;
      s = s | crc_start;
    end
    chk(s, 0);
    chk(c >= n && c <= n + 6, 1);
  endtask

  task acc(input logic [3:0] exp);
    @(posedge sys_clk);
    {chip_erase_req, prog_bus_req, prog_info_req} <= 3'h7;
    @(posedge sys_clk);
    {chip_erase_req, prog_bus_req, prog_info_req} <= 3'h0;
    #1 chk({eeprom_erase, prog_bus_grant, prog_info_grant, flash_erase}, exp);
  endtask

  task test_locked_gpio;
    start({8'h81, 8'h41, 8'h02, 8'h08, 8'h04, 8'h00});
    {gpio_oe_req, gpio_out_req} <= 2'h3;
    seq(1, 8);
    chk({osc_run_16m, osc_run_20m, osc_freq_trim, osc_temp_trim}, {2'h2, 8'h3a, 4'h5});
    rd(`FCD_OFS_CAL_B, rd_val);
    chk(rd_val, 8'h85);
    wr(`FCD_OFS_CAL_A, 8'h11);
    rd(`FCD_OFS_CAL_A, rd_val);
    chk(rd_val, 8'h3a);
    chk({crc_scan_source, crc_end_block, sections}, {2'h1, 9'h004, 9'h004, 9'h008});
    chk(shared_pin_function, FCD_PIN_GPIO);
    @(posedge sys_clk);
    fuse_bytes <= '0;
    wr(`FCD_OFS_OSC_CFG, 8'h55);
    rd(`FCD_OFS_OSC_CFG, rd_val);
    chk(rd_val, 8'h81);
    rd(8'h03, rd_val);
    chk(rd_val, 8'h00);
    acc(4'b1011);
    wr(`FCD_OFS_LOCK_KEY, 8'hc5);
    rd(`FCD_OFS_LOCK_KEY, rd_val);
    chk(rd_val, 8'hc5);
    acc(4'b0111);
    while ($time < t0 + 56000) @(posedge sys_clk);
    #1 chk({shared_pin_oe, pin_irq_allowed}, 0);
    while ($time < t0 + 64000) @(posedge sys_clk);
    #1 chk({shared_pin_oe, pin_irq_allowed}, 2'h3);
    chk(shared_pin_o, 1'b1);
    $display("locked gpio test done");
  endtask

  task test_open_reset_pin;
    start({8'h02, 8'hc8, 8'h00, 8'h00, 8'h00, 8'h00});
    gpio_out_req <= 1'b0;
    seq(0, 0);
    rd(`FCD_OFS_STATUS, rd_val);
    chk(rd_val, 8'h03);
    chk({osc_run_16m, osc_run_20m, osc_freq_trim, osc_temp_trim}, {2'h1, 8'h6c, 4'h9});
    wr(`FCD_OFS_CAL_A, 8'h11);
    rd(`FCD_OFS_CAL_A, rd_val);
    chk({rd_val, osc_freq_trim}, 16'h1111);
    rd(`FCD_OFS_CAL_B, rd_val);
    chk(rd_val, 8'h09);
    wr(`FCD_OFS_CAL_B, 8'hff);
    rd(`FCD_OFS_CAL_B, rd_val);
    chk({rd_val, osc_temp_trim}, {8'h0f, 4'hf});
    chk({crc_end_block, sections}, {9'h010, 9'h010, 9'h010});
    chk({shared_pin_function, shared_pin_oe, shared_pin_o}, {FCD_PIN_RESET, 2'b00});
    acc(4'b1011);
    $display("open reset pin test done");
  endtask

  task test_boot_app;
    start({8'h03, 8'h84, 8'h00, 8'h00, 8'h04, 8'hc5});
    seq(1, 0);
    rd(`FCD_OFS_STATUS, rd_val);
    chk(rd_val, 8'h17);
    chk({osc_run_16m, osc_run_20m}, 0);
    chk({crc_scan_source, crc_end_block, sections}, {2'h2, 9'h010, 9'h004, 9'h010});
    chk(shared_pin_function, FCD_PIN_PROG);
    acc(4'b1111);
    $display("boot app test done");
  endtask

  initial
  begin
    #300000;
    num_errors++;
    conclude;
  end

  initial
  begin
    test_locked_gpio;
    test_open_reset_pin;
    test_boot_app;
    conclude;
  end
endmodule
